// ---- hw/core_fetch_pkg.sv ----
package core_fetch_pkg;
  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 9;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] SMALL_MASK = 13'h0FFF;
  localparam logic [6:0] OFS_INDIRECT = 7'h00;
  localparam logic [6:0] OFS_PCL = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_FSR = 7'h04;
  localparam logic [6:0] OFS_PC_HIGH_LATCH = 7'h0A;
  localparam logic [6:0] OFS_GPR_BASE = 7'h20;
  localparam logic [6:0] OFS_COMMON = 7'h70;
  localparam int BANK_HI_BIT = 6;
  localparam int BANK_LO_BIT = 5;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] FSR_RESET = 8'h00;
  localparam logic [7:0] PC_HIGH_LATCH_RESET = 8'h00;
endpackage : core_fetch_pkg

// ---- hw/core_fetch_pipeline.sv ----
`timescale 1ns/1ps
`default_nettype none
module core_fetch_pipeline #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  output logic [12:0] prog_addr,
  input wire logic [13:0] prog_data,
  input wire logic irq_accept,
  input wire logic ex_branch,
  input wire logic [12:0] ex_target,
  input wire logic ex_rd_indirect,
  input wire logic ex_wr_en,
  input wire logic [7:0] ex_wr_data,
  output logic phase_one,
  output logic phase_two,
  output logic phase_three,
  output logic phase_four,
  output logic [13:0] exec_insn,
  output logic exec_valid,
  output logic [8:0] file_addr,
  output logic file_rd,
  output logic file_wr,
  output logic [7:0] file_wr_data,
  input wire logic [7:0] file_rd_data,
  output logic [7:0] operand_data,
  output logic file_is_special,
  output logic [12:0] pc_value,
  output logic [7:0] status_value,
  output logic [7:0] fsr_value
);
  typedef enum logic [1:0] {ph1, ph2, ph3, ph4} phase_e;
  phase_e phase_reg;
  logic [12:0] pc_reg;
  logic [13:0] fetch_reg;
  logic [13:0] insn_reg;
  logic fetch_ok_reg;
  logic exec_ok_reg;
  logic redirect_reg;
  logic [12:0] redirect_pc_reg;
  logic [7:0] status_reg;
  logic [7:0] fsr_reg;
  logic [7:0] pc_high_latch_reg;
  logic [7:0] operand_reg;
  logic [8:0] raw_addr;
  logic [8:0] eff_addr;
  logic [6:0] ofs;
  logic [12:0] pc_next;
  logic [12:0] pc_masked;
  logic adv;

  assign adv = clk_en;

  // four-phase sequencer, one phase per enabled clock
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= ph1;
    end else if (adv) begin
      case (phase_reg)
        ph1: phase_reg <= ph2;
        ph2: phase_reg <= ph3;
        ph3: phase_reg <= ph4;
        default: phase_reg <= ph1;
      endcase
    end
  end

  assign phase_one = (phase_reg == ph1);
  assign phase_two = (phase_reg == ph2);
  assign phase_three = (phase_reg == ph3);
  assign phase_four = (phase_reg == ph4);

  // wrap onto implemented words on the small part
  assign pc_masked = SMALL_VARIANT ? (pc_reg & core_fetch_pkg::SMALL_MASK) : pc_reg;
  assign prog_addr = pc_masked; // 13-bit fetch address

  // next pc: redirect target or plain increment
  always_comb begin
    if (redirect_reg) begin
      pc_next = redirect_pc_reg;
    end else begin
      pc_next = pc_reg + 13'h0001;
    end
  end

  // program counter steps in phase one
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_reg <= core_fetch_pkg::RESET_VECTOR;
    end else if (adv && phase_one) begin
      pc_reg <= pc_next;
    end
  end

  // pending redirect, taken at next phase one; interrupt has priority
  always_ff @(posedge clk) begin
    if (rst) begin
      redirect_reg <= 1'b0;
      redirect_pc_reg <= core_fetch_pkg::RESET_VECTOR;
    end else if (adv) begin
      if (phase_four && irq_accept) begin
        redirect_reg <= 1'b1;
        redirect_pc_reg <= core_fetch_pkg::IRQ_VECTOR;
      end else if (phase_four && exec_ok_reg && ex_branch) begin
        redirect_reg <= 1'b1;
        redirect_pc_reg <= ex_target;
      end else if (phase_one) begin
        redirect_reg <= 1'b0;
      end
    end
  end

  // fetch stage: word captured in phase four
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_reg <= 14'h0000;
      fetch_ok_reg <= 1'b0;
    end else if (adv && phase_four) begin
      fetch_reg <= prog_data;
      // a branch or interrupt voids the word fetched meanwhile
      fetch_ok_reg <= ~(irq_accept | (exec_ok_reg & ex_branch));
    end
  end

  // execute stage latches the prefetched word in phase one
  always_ff @(posedge clk) begin
    if (rst) begin
      insn_reg <= 14'h0000;
      exec_ok_reg <= 1'b0;
    end else if (adv && phase_one) begin
      insn_reg <= fetch_reg;
      exec_ok_reg <= fetch_ok_reg & ~redirect_reg; // flushed slot runs as no-op
    end
  end

  assign exec_insn = insn_reg;
  assign exec_valid = exec_ok_reg;
  assign pc_value = pc_reg;

  // direct address: bank bits over seven-bit offset
  assign raw_addr = {status_reg[core_fetch_pkg::BANK_HI_BIT],
                     status_reg[core_fetch_pkg::BANK_LO_BIT], insn_reg[6:0]};

  // address resolution: indirect redirect and common region fold
  always_comb begin
    if (ex_rd_indirect || insn_reg[6:0] == core_fetch_pkg::OFS_INDIRECT) begin
      eff_addr = {status_reg[7], fsr_reg}; // pointer access
    end else begin
      eff_addr = raw_addr;
    end
    if (eff_addr[8:7] != 2'b00 && eff_addr[6:0] >= core_fetch_pkg::OFS_COMMON) begin
      eff_addr = {2'b00, eff_addr[6:0]}; // shared top block
    end
  end

  assign ofs = eff_addr[6:0];
  assign file_addr = eff_addr;
  // special region below the GPR base, static RAM above
  assign file_is_special = (ofs < core_fetch_pkg::OFS_GPR_BASE);
  // data read in phase two, written in phase four
  assign file_rd = exec_ok_reg && phase_two;
  assign file_wr = exec_ok_reg && phase_four && ex_wr_en;
  assign file_wr_data = ex_wr_data;

  // operand capture and readback of core registers, same in every bank
  always_ff @(posedge clk) begin
    if (rst) begin
      operand_reg <= 8'h00;
    end else if (adv && file_rd) begin
      if (ofs == core_fetch_pkg::OFS_PCL) begin
        operand_reg <= pc_reg[7:0];
      end else if (ofs == core_fetch_pkg::OFS_STATUS) begin
        operand_reg <= status_reg;
      end else if (ofs == core_fetch_pkg::OFS_FSR) begin
        operand_reg <= fsr_reg;
      end else if (ofs == core_fetch_pkg::OFS_PC_HIGH_LATCH) begin
        operand_reg <= pc_high_latch_reg;
      end else begin
        operand_reg <= file_rd_data;
      end
    end
  end

  assign operand_data = operand_reg;

  // core register writes in phase four, decoded at any bank
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= core_fetch_pkg::STATUS_RESET;
      fsr_reg <= core_fetch_pkg::FSR_RESET;
      pc_high_latch_reg <= core_fetch_pkg::PC_HIGH_LATCH_RESET;
    end else if (adv && file_wr) begin
      if (ofs == core_fetch_pkg::OFS_STATUS) begin
        status_reg <= ex_wr_data; // bank bits 6:5
      end else if (ofs == core_fetch_pkg::OFS_FSR) begin
        fsr_reg <= ex_wr_data;
      end else if (ofs == core_fetch_pkg::OFS_PC_HIGH_LATCH) begin
        pc_high_latch_reg <= ex_wr_data;
      end
    end
  end

  assign status_value = status_reg;
  assign fsr_value = fsr_reg;
endmodule : core_fetch_pipeline
`default_nettype wire

// ---- sim/core_fetch_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module core_fetch_assertions #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [12:0] prog_addr,
  input wire logic irq_accept,
  input wire logic ex_branch,
  input wire logic ex_rd_indirect,
  input wire logic phase_one,
  input wire logic phase_two,
  input wire logic phase_four,
  input wire logic [13:0] exec_insn,
  input wire logic exec_valid,
  input wire logic [8:0] file_addr,
  input wire logic file_rd,
  input wire logic file_wr,
  input wire logic [12:0] pc_value,
  input wire logic [7:0] status_value,
  input wire logic [7:0] fsr_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // phase order, counter and data strobes
  AST_PH_SEQ: assert property (phase_one && clk_en |=> phase_two)
    else $error("phase two missing");
  // a redirect taken in the phase four just before loads the target instead
  AST_PC_INC: assert property (
    phase_one && clk_en && !$past(irq_accept || (ex_branch && exec_valid))
    |=> pc_value == $past(pc_value) + 13'h0001)
    else $error("pc not stepped");
  // execute word only changes on the phase one edge
  AST_LATCH: assert property ($changed(exec_insn) |-> phase_two)
    else $error("execute word latched off phase one");
  AST_RD_PH2: assert property (file_rd |-> phase_two && exec_valid)
    else $error("read off phase two");
  AST_WR_PH4: assert property (file_wr |-> phase_four && exec_valid)
    else $error("write off phase four");
  AST_FLUSH: assert property (
    phase_four && clk_en && (irq_accept || ex_branch && exec_valid)
    |-> ##[1:5] !exec_valid)
    else $error("prefetch not flushed");
  // data and fetch address forming
  AST_BANK: assert property (
    exec_valid && !ex_rd_indirect && exec_insn[6:0] >= 7'h20
    && exec_insn[6:0] < 7'h70 |-> file_addr == {status_value[6:5], exec_insn[6:0]})
    else $error("bank address wrong");
  AST_IND: assert property (
    exec_valid && (ex_rd_indirect || exec_insn[6:0] == 7'h00)
    && fsr_value[6:0] >= 7'h20 && fsr_value[6:0] < 7'h70
    |-> file_addr == {status_value[7], fsr_value})
    else $error("indirect address wrong");
  AST_PROG: assert property (
    prog_addr == (SMALL_VARIANT ? (pc_value & core_fetch_pkg::SMALL_MASK) : pc_value))
    else $error("fetch address wrong");
endmodule : core_fetch_assertions
`default_nettype wire

// ---- sim/prog_file_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module prog_file_model (
  input wire logic [12:0] prog_addr,
  output logic [13:0] prog_data,
  input wire logic [8:0] file_addr,
  input wire logic file_rd,
  output logic [7:0] file_rd_data
);
  // word holds its own address; idle read bus shows inverted data
  assign prog_data = {1'b0, prog_addr};
  assign file_rd_data = file_rd ? (file_addr[7:0] ^ 8'hA5) : ~(file_addr[7:0] ^ 8'hA5);
endmodule : prog_file_model
`default_nettype wire

// ---- sim/core_fetch_pipeline_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module core_fetch_pipeline_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic irq_accept = 1'b0;
  logic ex_branch = 1'b0;
  logic [12:0] ex_target = 13'h0100;
  logic ex_rd_indirect = 1'b0;
  logic ex_wr_en = 1'b0;
  logic [7:0] ex_wr_data = 8'h00;
  logic [12:0] prog_addr, pc_value;
  logic [13:0] prog_data, exec_insn;
  logic [8:0] file_addr;
  logic [7:0] file_rd_data, file_wr_data, operand_data, status_value, fsr_value;
  logic phase_one, phase_two, phase_three, phase_four, exec_valid, file_rd, file_wr;
  logic file_is_special;
  int failures = 0;
  int cmp_count = 0;
  core_fetch_pipeline i_core_fetch_pipeline (.*);
  prog_file_model i_prog_file_model (.*);
  // clock
  always #20 clk = ~clk;
  task step;
    @(posedge clk);
    #1;
  endtask : step
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task wait_exec(input logic [13:0] w, input int bound);
    int n;
    n = 0;
    cmp_count++;
    while (!(exec_valid === 1'b1 && exec_insn === w) && n < bound) begin
      step();
      n++;
    end
    if (n >= bound) begin
      failures++;
      $display("BAD %0t no slot %h", $time, w);
      test_done();
    end
  endtask : wait_exec
  task wr_at(input logic [13:0] w, input logic [7:0] d);
    wait_exec(w, 600);
    ex_wr_en = 1'b1;
    ex_wr_data = d;
    repeat (4) step();
    ex_wr_en = 1'b0;
  endtask : wr_at
  task redirect(input logic irq, input logic [13:0] w);
    for (int i = 0; i < 8 && phase_four !== 1'b1; i++) step();
    irq_accept = irq;
    ex_branch = !irq;
    step();
    irq_accept = 1'b0;
    ex_branch = 1'b0;
    wait_exec(w, 12);
  endtask : redirect
  // main sequence
  initial begin
    repeat (4) step();
    chk({3'h0, pc_value}, 16'h0000);
    chk({8'h00, fsr_value}, 16'h0000);
    rst = 1'b0;
    step();
    chk({15'h0, phase_two}, 16'h0001);
    chk({3'h0, pc_value}, 16'h0001);
    wr_at(14'h0003, 8'h60);
    wr_at(14'h0004, 8'h35);
    chk({14'h0, status_value[6:5]}, 16'h0003);
    chk({8'h00, fsr_value}, 16'h0035);
    wait_exec(14'h000A, 40);
    chk({15'h0, file_is_special}, 16'h0001);
    chk({9'h0, file_addr[6:0]}, 16'h000A);
    ex_rd_indirect = 1'b1;
    #1;
    chk({7'h0, file_addr}, 16'h0035);
    ex_rd_indirect = 1'b0;
    wait_exec(14'h0030, 200);
    chk({7'h0, file_addr}, 16'h01B0);
    chk({15'h0, file_is_special}, 16'h0000);
    step();
    chk({8'h00, operand_data}, 16'h0015);
    wait_exec(14'h0075, 300);
    chk({7'h0, file_addr}, 16'h0075);
    // enable low holds phase and counter where they are
    clk_en = 1'b0;
    repeat (3) step();
    chk({3'h0, pc_value}, 16'h0076);
    chk({15'h0, phase_two}, 16'h0001);
    clk_en = 1'b1;
    redirect(1'b0, 14'h0100);
    redirect(1'b1, 14'h0004);
    wait_exec(14'h0005, 5);
    test_done();
  end
endmodule : core_fetch_pipeline_test
bind core_fetch_pipeline core_fetch_assertions #(.SMALL_VARIANT(SMALL_VARIANT)) i_chk (.*);
`default_nettype wire
